/* File: core/fcl_pkg.sv */
package fcl_pkg;
  localparam int AW = 4;
  localparam int FUSE_DEPTH = 11;
  // fuse byte offsets
  localparam logic [3:0] A_WDT  = 4'h0;
  localparam logic [3:0] A_BOD  = 4'h1;
  localparam logic [3:0] A_OSC  = 4'h2;
  localparam logic [3:0] A_SYS0 = 4'h5;
  localparam logic [3:0] A_SYS1 = 4'h6;
  localparam logic [3:0] A_APP  = 4'h7;
  localparam logic [3:0] A_BOOT = 4'h8;
  localparam logic [3:0] A_LOCK = 4'ha;
  // factory values
  localparam logic [7:0] RST_WDT  = 8'h00;
  localparam logic [7:0] RST_BOD  = 8'h00;
  localparam logic [7:0] RST_OSC  = 8'h02;
  localparam logic [7:0] RST_SYS0 = 8'hc0;
  localparam logic [7:0] RST_SYS1 = 8'h07;
  localparam logic [7:0] RST_APP  = 8'h00;
  localparam logic [7:0] RST_BOOT = 8'h00;
  localparam logic [7:0] RST_LOCK = 8'hc5;
  localparam logic [7:0] OPEN_KEY = 8'hc5;
  // bits that are reserved and must stay zero
  localparam logic [7:0] RSV_OSC  = 8'h7c;
  localparam logic [7:0] RSV_SYS0 = 8'h36;
  localparam logic [7:0] RSV_SYS1 = 8'hf8;
  // field positions
  localparam int WIN_LO = 4;
  localparam int PER_LO = 0;
  localparam int LVL_LO = 5;
  localparam int SMP_BIT = 4;
  localparam int ACT_LO = 2;
  localparam int SLP_LO = 0;
  localparam int FRZ_BIT = 7;
  localparam int FSEL_LO = 0;
  localparam int CRC_LO = 6;
  localparam int RPIN_BIT = 3;
  localparam int EEK_BIT = 0;
  localparam int SUT_LO = 0;
  localparam logic [1:0] FSEL_16M = 2'h1;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } fcl_state_e;
endpackage

/* File: core/fcl_fuse_config_loader.sv */
`timescale 1ns/1ps
module fcl_fuse_config_loader
  import fcl_pkg::*;
#(
  parameter int STARTUP_MS_CYCLES = fcl_pkg::MS_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             power_on,
  input  wire logic             cpu_re,
  input  wire logic             cpu_we,
  input  wire logic [fcl_pkg::AW-1:0] cpu_addr,
  output logic [7:0]            cpu_rdata,
  input  wire logic             prog_re,
  input  wire logic             prog_we,
  input  wire logic             prog_clear,
  input  wire logic [fcl_pkg::AW-1:0] prog_addr,
  input  wire logic [7:0]       prog_wdata,
  output logic [7:0]            prog_rdata,
  input  wire logic [6:0]       cal16_freq,
  input  wire logic [3:0]       cal16_temp,
  input  wire logic [6:0]       cal20_freq,
  input  wire logic [3:0]       cal20_temp,
  input  wire logic             wdt_sw_we,
  input  wire logic [7:0]       wdt_sw_data,
  input  wire logic             osc_cal_we,
  input  wire logic [6:0]       osc_cal_wdata_a,
  input  wire logic [3:0]       osc_cal_wdata_b,
  output logic [3:0]            wdt_window,
  output logic [3:0]            wdt_period,
  output logic [2:0]            brownout_threshold_level,
  output logic                  brownout_sample_rate,
  output logic [1:0]            brownout_active_mode,
  output logic [1:0]            brownout_sleep_mode,
  output logic                  oscillator_cal_freeze,
  output logic [1:0]            rc_frequency_select,
  output logic [6:0]            osc_frequency_trim,
  output logic [3:0]            osc_temperature_trim,
  output logic [1:0]            startup_check_source,
  output logic                  reset_pin_function,
  output logic                  eeprom_keep_on_erase,
  output logic [7:0]            app_code_end,
  output logic [7:0]            boot_section_end,
  output logic                  device_locked,
  output logic                  cpu_run
);
  import fcl_pkg::*;

  fcl_state_e  state_r, state_nxt;
  logic [7:0]  fuse_mem [FUSE_DEPTH];
  logic [7:0]  mem_nxt [FUSE_DEPTH];
  logic        por_pend_r, por_pend_nxt;
  logic [23:0] tick_r, tick_nxt;
  logic [6:0]  ms_r, ms_nxt, sut_ms;
  logic [7:0]  wdt_r, wdt_nxt, bod_r, bod_nxt;
  logic [7:0]  sys0_r, sys0_nxt, sys1_r, sys1_nxt;
  logic [7:0]  app_r, app_nxt, boot_r, boot_nxt;
  logic        lock_r, lock_nxt, frz_r, frz_nxt;
  logic [1:0]  fsel_r, fsel_nxt;
  logic [6:0]  cal_a_r, cal_a_nxt;
  logic [3:0]  cal_b_r, cal_b_nxt;
  logic [7:0]  cpu_rd_r, cpu_rd_nxt, prg_rd_r, prg_rd_nxt;
  logic        go, loading;

  assign go = clk_en & ~sys_rst;
  assign loading = (state_r == ST_LOAD);

  // read mux: reserved offsets and holes read as zero
  function automatic logic [7:0] fuse_rd(input logic [AW-1:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a < AW'(FUSE_DEPTH) && a != 4'h3 && a != 4'h4 && a != 4'h9) begin
      d = fuse_mem[a];
    end
    return d;
  endfunction

  // reserved-bit mask per offset
  function automatic logic [7:0] rsv_mask(input logic [AW-1:0] a);
    logic [7:0] m;
    case (a)
      A_OSC:   m = RSV_OSC;
      A_SYS0:  m = RSV_SYS0;
      A_SYS1:  m = RSV_SYS1;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // nonvolatile cells: only the programming port changes them
  always_comb begin
    mem_nxt = fuse_mem;
    if (clk_en && prog_clear) begin
      // erase is taken even in reset, so blank cells never reach a load
      mem_nxt[A_WDT]  = RST_WDT;
      mem_nxt[A_BOD]  = RST_BOD;
      mem_nxt[A_OSC]  = RST_OSC;
      mem_nxt[A_SYS0] = RST_SYS0;
      mem_nxt[A_SYS1] = RST_SYS1;
      mem_nxt[A_APP]  = RST_APP;
      mem_nxt[A_BOOT] = RST_BOOT;
      mem_nxt[A_LOCK] = RST_LOCK;
      mem_nxt[4'h3] = 8'h00;
      mem_nxt[4'h4] = 8'h00;
      mem_nxt[4'h9] = 8'h00;
    end else if (go && prog_we && !lock_r && prog_addr < AW'(FUSE_DEPTH)) begin
      // cpu_we never reaches here; reserved bits forced low anyway
      mem_nxt[prog_addr] = prog_wdata & ~rsv_mask(prog_addr);
    end
  end

  // no reset: contents survive every reset like real fuses
  always_ff @(posedge mclk) begin
    fuse_mem <= mem_nxt;
  end

  // start-up sequencer: copy, optional power-on delay, release cpu
  always_comb begin
    state_nxt    = state_r;
    por_pend_nxt = por_pend_r;
    tick_nxt     = tick_r;
    ms_nxt       = ms_r;
    sut_ms       = (sys1_r[SUT_LO+:3] == 3'h0) ? 7'h00 :
                   7'(7'h01 << (sys1_r[SUT_LO+:3] - 3'h1));
    if (sys_rst) begin
      por_pend_nxt = por_pend_r | power_on;
    end else if (clk_en) begin
      case (state_r)
        ST_LOAD: begin
          tick_nxt  = 24'h000000;
          ms_nxt    = 7'h00;
          // delay while a power-on start is still pending; a warm reset delays only if that delay was cut short
          state_nxt = por_pend_r ? ST_DELAY : ST_RUN;
        end
        ST_DELAY: begin
          if (ms_r >= sut_ms) begin
            state_nxt    = ST_RUN;
            por_pend_nxt = 1'b0;
          end else if (tick_r == 24'(STARTUP_MS_CYCLES - 1)) begin
            tick_nxt = 24'h000000;
            ms_nxt   = ms_r + 7'h01;
          end else begin
            tick_nxt = tick_r + 24'h000001;
          end
        end
        ST_RUN: state_nxt = ST_RUN;
        default: state_nxt = ST_LOAD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    por_pend_r <= por_pend_nxt;
    if (sys_rst) begin
      state_r <= ST_LOAD;
      tick_r  <= 24'h000000;
      ms_r    <= 7'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      tick_r  <= tick_nxt;
      ms_r    <= ms_nxt;
    end
  end

  // target fields: written only in the load cycle or by software
  always_comb begin
    wdt_nxt   = wdt_r;
    bod_nxt   = bod_r;
    sys0_nxt  = sys0_r;
    sys1_nxt  = sys1_r;
    app_nxt   = app_r;
    boot_nxt  = boot_r;
    lock_nxt  = lock_r;
    frz_nxt   = frz_r;
    fsel_nxt  = fsel_r;
    cal_a_nxt = cal_a_r;
    cal_b_nxt = cal_b_r;
    if (go && loading) begin
      wdt_nxt  = fuse_mem[A_WDT];
      if (por_pend_r) begin
        bod_nxt = fuse_mem[A_BOD];
      end
      sys0_nxt = fuse_mem[A_SYS0];
      sys1_nxt = fuse_mem[A_SYS1];
      app_nxt  = fuse_mem[A_APP];
      boot_nxt = fuse_mem[A_BOOT];
      lock_nxt = (fuse_mem[A_LOCK] != OPEN_KEY);
      frz_nxt  = fuse_mem[A_OSC][FRZ_BIT];
      fsel_nxt = fuse_mem[A_OSC][FSEL_LO+:2];
      // reserved codes fall back to the 20 MHz trims
      if (fuse_mem[A_OSC][FSEL_LO+:2] == FSEL_16M) begin
        cal_a_nxt = cal16_freq;
        cal_b_nxt = cal16_temp;
      end else begin
        cal_a_nxt = cal20_freq;
        cal_b_nxt = cal20_temp;
      end
    end else if (go) begin
      if (wdt_sw_we) begin
        wdt_nxt = wdt_sw_data;
      end
      if (osc_cal_we && !frz_r) begin
        cal_a_nxt = osc_cal_wdata_a;
        cal_b_nxt = osc_cal_wdata_b;
      end
    end
  end

  // brown-out copy has no reset so warm resets keep it
  always_ff @(posedge mclk) begin
    bod_r <= bod_nxt;
    if (sys_rst) begin
      wdt_r   <= RST_WDT;
      sys0_r  <= RST_SYS0;
      sys1_r  <= RST_SYS1;
      app_r   <= RST_APP;
      boot_r  <= RST_BOOT;
      lock_r  <= 1'b1;
      frz_r   <= 1'b0;
      fsel_r  <= RST_OSC[FSEL_LO+:2];
      cal_a_r <= 7'h00;
      cal_b_r <= 4'h0;
    end else begin
      wdt_r   <= wdt_nxt;
      sys0_r  <= sys0_nxt;
      sys1_r  <= sys1_nxt;
      app_r   <= app_nxt;
      boot_r  <= boot_nxt;
      lock_r  <= lock_nxt;
      frz_r   <= frz_nxt;
      fsel_r  <= fsel_nxt;
      cal_a_r <= cal_a_nxt;
      cal_b_r <= cal_b_nxt;
    end
  end

  // read ports: one cycle latency; locked debug reads see zero
  always_comb begin
    cpu_rd_nxt = cpu_rd_r;
    prg_rd_nxt = prg_rd_r;
    if (go && cpu_re) begin
      cpu_rd_nxt = fuse_rd(cpu_addr);
    end
    if (go && prog_re) begin
      prg_rd_nxt = lock_r ? 8'h00 : fuse_rd(prog_addr);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cpu_rd_r <= 8'h00;
      prg_rd_r <= 8'h00;
    end else begin
      cpu_rd_r <= cpu_rd_nxt;
      prg_rd_r <= prg_rd_nxt;
    end
  end

  assign cpu_rdata                = cpu_rd_r;
  assign prog_rdata               = prg_rd_r;
  assign wdt_window               = wdt_r[WIN_LO+:4];
  assign wdt_period               = wdt_r[PER_LO+:4];
  assign brownout_threshold_level = bod_r[LVL_LO+:3];
  assign brownout_sample_rate     = bod_r[SMP_BIT];
  assign brownout_active_mode     = bod_r[ACT_LO+:2];
  assign brownout_sleep_mode      = bod_r[SLP_LO+:2];
  assign oscillator_cal_freeze    = frz_r;
  assign rc_frequency_select      = fsel_r;
  assign osc_frequency_trim       = cal_a_r;
  assign osc_temperature_trim     = cal_b_r;
  assign startup_check_source     = sys0_r[CRC_LO+:2];
  assign reset_pin_function       = sys0_r[RPIN_BIT];
  assign eeprom_keep_on_erase     = sys0_r[EEK_BIT];
  assign app_code_end             = app_r;
  assign boot_section_end         = boot_r;
  assign device_locked            = lock_r;
  assign cpu_run                  = (state_r == ST_RUN);

  sequence load_go_s;
    go && loading;
  endsequence
  sequence release_s;
    sys_rst ##1 !sys_rst;
  endsequence

  wdt_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
    load_go_s |=> wdt_window == $past(fuse_mem[A_WDT][7:4])
      && wdt_period == $past(fuse_mem[A_WDT][3:0]))
    else $error("watchdog fields not loaded");
  bod_load_a: assert property (@(posedge mclk) disable iff (sys_rst)
    load_go_s ##0 por_pend_r |=> brownout_threshold_level ==
      $past(fuse_mem[A_BOD][7:5]) && brownout_sample_rate == $past(fuse_mem[A_BOD][4]))
    else $error("brown-out not loaded after power-on");
  bod_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
    load_go_s ##0 !por_pend_r |=> $stable(bod_r))
    else $error("brown-out changed on warm reset");
  osc_freeze_a: assert property (@(posedge mclk) disable iff (sys_rst)
    go && !loading && osc_cal_we && oscillator_cal_freeze |=> $stable(cal_a_r))
    else $error("frozen calibration was modified");
  trim_pick_a: assert property (@(posedge mclk) disable iff (sys_rst)
    load_go_s ##0 fuse_mem[A_OSC][1:0] == FSEL_16M |=>
      osc_frequency_trim == $past(cal16_freq))
    else $error("16 MHz trim not chosen");
  cpu_hold_a: assert property (@(posedge mclk)
    release_s |-> !cpu_run)
    else $error("cpu released before copy");
  lock_key_a: assert property (@(posedge mclk) disable iff (sys_rst)
    load_go_s |=> device_locked == ($past(fuse_mem[A_LOCK]) != OPEN_KEY))
    else $error("lock state wrong");
  dbg_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
    go && prog_re && device_locked |=> prog_rdata == 8'h00)
    else $error("locked debug read leaked data");
  lock_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    go && (prog_we || cpu_we) && device_locked && !prog_clear
      |=> $stable(fuse_mem[A_WDT]) && $stable(fuse_mem[A_LOCK]))
    else $error("fuse changed without permission");
endmodule // fcl_fuse_config_loader

/* File: verif/fcl_prog_host.sv */
`timescale 1ns/1ps
module fcl_prog_host
  import fcl_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic [7:0]             prog_rdata,
  output logic                        prog_re,
  output logic                        prog_we,
  output logic                        prog_clear,
  output logic [fcl_pkg::AW-1:0]      prog_addr,
  output logic [7:0]                  prog_wdata
);
  // idle bus before the first request
  initial begin
    {prog_clear, prog_we, prog_re} = 3'h0;
    prog_addr = 4'h0;
    prog_wdata = 8'h00;
  end

  // one request held over a single taking edge; kind is {clear, write, read}
  task automatic req(input logic [2:0] kind, input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    {prog_clear, prog_we, prog_re} = kind;
    prog_addr = a;
    prog_wdata = d & ~(a == A_OSC ? RSV_OSC : a == A_SYS0 ? RSV_SYS0 :
                       a == A_SYS1 ? RSV_SYS1 : 8'h00);
    @(negedge mclk);
    {prog_clear, prog_we, prog_re} = 3'h0;
    // released lines scramble so a stale value is never mistaken for data
    prog_addr = ~prog_addr;
    prog_wdata = ~prog_wdata;
  endtask
endmodule // fcl_prog_host

/* File: verif/fcl_fuse_config_loader_tb.sv */
`timescale 1ns/1ps
module fcl_fuse_config_loader_tb;
  import fcl_pkg::*;
  typedef struct {int sel; logic [7:0] exp;} fcl_note_s;
  logic mclk, sys_rst, clk_en, power_on, cpu_re, cpu_we, wdt_sw_we, osc_cal_we;
  logic [3:0] cpu_addr, cal16_temp, cal20_temp, osc_cal_wdata_b, wdt_window, wdt_period, ttrim;
  logic [6:0] cal16_freq, cal20_freq, osc_cal_wdata_a, ftrim;
  logic [7:0] cpu_rdata, prog_rdata, wdt_sw_data, app, boot, prog_wdata, w, b, bl;
  logic [2:0] lvl;
  logic [1:0] act, slp, fsel, crc;
  logic       rate, frz, rpin, eek, locked, run, prog_re, prog_we, prog_clear;
  logic [3:0] prog_addr;
  logic [31:0] seed = 32'hc4bd7534;
  logic [7:0] ob [12];
  string      nm [12] = '{"cpu_rd", "prog_rd", "wdt", "bod", "osc", "sys0", "app", "boot",
                          "lock", "run", "trim_f", "trim_t"};
  fcl_note_s  q [$];
  fcl_note_s  n;
  int         checks = 0;
  int         n_fail = 0;

  fcl_fuse_config_loader #(.STARTUP_MS_CYCLES(4)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .power_on(power_on),
    .cpu_re(cpu_re), .cpu_we(cpu_we), .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata),
    .prog_re(prog_re), .prog_we(prog_we), .prog_clear(prog_clear), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .prog_rdata(prog_rdata), .cal16_freq(cal16_freq),
    .cal16_temp(cal16_temp), .cal20_freq(cal20_freq), .cal20_temp(cal20_temp),
    .wdt_sw_we(wdt_sw_we), .wdt_sw_data(wdt_sw_data), .osc_cal_we(osc_cal_we),
    .osc_cal_wdata_a(osc_cal_wdata_a), .osc_cal_wdata_b(osc_cal_wdata_b),
    .wdt_window(wdt_window), .wdt_period(wdt_period), .brownout_threshold_level(lvl),
    .brownout_sample_rate(rate), .brownout_active_mode(act), .brownout_sleep_mode(slp),
    .oscillator_cal_freeze(frz), .rc_frequency_select(fsel), .osc_frequency_trim(ftrim),
    .osc_temperature_trim(ttrim), .startup_check_source(crc), .reset_pin_function(rpin),
    .eeprom_keep_on_erase(eek), .app_code_end(app), .boot_section_end(boot),
    .device_locked(locked), .cpu_run(run));

  fcl_prog_host host (.mclk(mclk), .prog_rdata(prog_rdata), .prog_re(prog_re),
    .prog_we(prog_we), .prog_clear(prog_clear), .prog_addr(prog_addr), .prog_wdata(prog_wdata));

  // outputs regrouped into fuse-byte layout so expectations are plain fuse values
  always_comb ob = '{cpu_rdata, prog_rdata, {wdt_window, wdt_period}, {lvl, rate, act, slp},
                     {frz, 5'h00, fsel}, {crc, 2'h0, rpin, 2'h0, eek}, app, boot,
                     {7'h00, locked}, {7'h00, run}, {1'b0, ftrim}, {4'h0, ttrim}};

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // monitor: oldest note against what the outputs show now
  initial forever begin
    wait (q.size() > 0);
    n = q.pop_front();
    checks++;
    if (ob[n.sel] !== n.exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm[n.sel], n.exp, ob[n.sel]);
    end
  end

  function automatic logic [31:0] nx();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic note(input int s, input logic [7:0] e);
    q.push_back('{s, e});
  endtask

  task automatic fields(input logic [7:0] fw, fb, fo, fs);
    note(2, fw);
    note(3, fb);
    note(4, fo & 8'h83);
    note(5, fs & 8'hc9);
  endtask

  task automatic rst(input logic pon);
    @(negedge mclk);
    sys_rst = 1'b1;
    power_on = pon;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
  endtask

  // bounded wait for release; fields are checked the moment the cpu may run
  task automatic run_wait;
    for (int i = 0; i < 2000 && run !== 1'b1; i++) @(negedge mclk);
    note(9, 8'h01);
  endtask

  task automatic cpu_rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk);
    cpu_re = 1'b1;
    cpu_addr = a;
    @(negedge mclk);
    cpu_re = 1'b0;
    cpu_addr = ~a;
    note(0, e);
  endtask

  task automatic tally_and_finish;
    @(negedge mclk);
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    {sys_rst, power_on, clk_en, cpu_re, cpu_we, wdt_sw_we, osc_cal_we} = 7'h70;
    cpu_addr = 4'h0;
    wdt_sw_data = 8'h3c;
    cal16_freq = 7'(nx());
    cal16_temp = 4'(nx());
    cal20_freq = 7'(nx());
    cal20_temp = 4'(nx());
    osc_cal_wdata_a = 7'(nx());
    osc_cal_wdata_b = 4'(nx());
    // cells start unknown: erase while the power-on reset is held, then release
    host.req(3'h4, 4'h0, 8'h00);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    note(9, 8'h00);
    run_wait();
    fields(RST_WDT, RST_BOD, RST_OSC, RST_SYS0);
    note(8, 8'h00);
    note(10, {1'b0, cal20_freq});
    cpu_rd(A_SYS1, RST_SYS1);
    cpu_rd(4'h3, 8'h00);
    w = 8'(nx());
    b = 8'(nx());
    host.req(3'h2, A_WDT, w);
    host.req(3'h2, A_BOD, b);
    host.req(3'h2, A_OSC, 8'h81);
    host.req(3'h2, A_SYS0, 8'h49);
    host.req(3'h2, A_SYS1, 8'h01);
    host.req(3'h2, A_APP, b ^ 8'h5a);
    host.req(3'h2, A_BOOT, w ^ 8'ha5);
    host.req(3'h1, A_BOD, 8'h00);
    note(1, b);
    note(2, RST_WDT);
    @(negedge mclk);
    cpu_we = 1'b1;
    cpu_addr = A_WDT;
    @(negedge mclk);
    cpu_we = 1'b0;
    cpu_rd(A_WDT, w);
    rst(1'b0);
    run_wait();
    fields(w, RST_BOD, 8'h81, 8'h49);
    note(6, b ^ 8'h5a);
    note(7, w ^ 8'ha5);
    note(10, {1'b0, cal16_freq});
    note(11, {4'h0, cal16_temp});
    // frozen calibration must ignore a run-time trim write
    @(negedge mclk);
    osc_cal_we = 1'b1;
    wdt_sw_we = 1'b1;
    @(negedge mclk);
    {osc_cal_we, wdt_sw_we} = 2'h0;
    note(10, {1'b0, cal16_freq});
    note(2, 8'h3c);
    rst(1'b1);
    run_wait();
    fields(w, b, 8'h81, 8'h49);
    // every check source and mode code, each through a power-on start
    for (int k = 0; k < 4; k++) begin
      bl = {(k == 0) ? 3'h0 : (k == 1) ? 3'h2 : 3'h7, k[0], k[1:0], k[1:0]};
      host.req(3'h2, A_BOD, bl);
      host.req(3'h2, A_SYS0, {k[1:0], 6'h09});
      rst(1'b1);
      run_wait();
      fields(w, bl, 8'h81, {k[1:0], 6'h09});
    end
    host.req(3'h2, A_LOCK, 8'h00);
    rst(1'b0);
    run_wait();
    note(8, 8'h01);
    host.req(3'h1, A_WDT, 8'h00);
    note(1, 8'h00);
    host.req(3'h2, A_WDT, 8'h11);
    cpu_rd(A_WDT, w);
    cpu_rd(A_LOCK, 8'h00);
    host.req(3'h4, 4'h0, 8'h00);
    rst(1'b0);
    run_wait();
    fields(RST_WDT, bl, RST_OSC, RST_SYS0);
    note(8, 8'h00);
    @(negedge mclk);
    osc_cal_we = 1'b1;
    @(negedge mclk);
    osc_cal_we = 1'b0;
    note(10, {1'b0, osc_cal_wdata_a});
    note(11, {4'h0, osc_cal_wdata_b});
    tally_and_finish();
  end
endmodule // fcl_fuse_config_loader_tb
